// *** pkg/lfs_pkg.sv ***
// constants and types shared by the led fault supervisor files
`default_nettype none
package lfs_pkg;
	// clock rate
	localparam int CLK_MHZ = 125;
	// hiccup retry period, pwm fault mask and fault deglitch times
	localparam int HICCUP_TIME_MS = 1;
	localparam int MASK_TIME_US = 130;
	localparam int DEGLITCH_TIME_US = 10;
	// cycle counts; all figures are whole cycles at 125 MHz so no rounding is lost
	localparam int HICCUP_CYC = HICCUP_TIME_MS * 1000 * CLK_MHZ;
	localparam int MASK_CYC = MASK_TIME_US * CLK_MHZ;
	localparam int DEGLITCH_CYC = DEGLITCH_TIME_US * CLK_MHZ;
	// current to regulation timer length in switching cycles
	localparam int REG_SW_CYCLES = 256;
	// counter widths
	localparam int CNT_W = 17;
	localparam int REG_CNT_W = 9;
	// apb register map, byte addresses
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	// control register fields
	localparam int CTRL_SUP_EN_BIT = 0;
	localparam logic CTRL_SUP_EN_RST = 1'h1;
	// status register fields
	localparam int ST_FLAG_BIT = 0;
	localparam int ST_OPEN_BIT = 1;
	localparam int ST_SHORT_BIT = 2;
	localparam int ST_HIC_BIT = 3;
	localparam int ST_MASK_BIT = 4;
	localparam int ST_REGOK_BIT = 5;
	localparam int ST_PWM_BIT = 6;
	// register decode results
	typedef enum logic [1:0] {
		LFS_REG_NONE = 2'h0,
		LFS_REG_CTRL = 2'h1,
		LFS_REG_STATUS = 2'h2
	} lfs_reg_t;
	// regulator supervision states
	typedef enum logic [2:0] {
		LFS_RUN = 3'b001,
		LFS_HIC = 3'b010,
		LFS_RST = 3'b100
	} lfs_state_t;
endpackage
`default_nettype wire

// *** pkg/lfs_tmr_if.sv ***
// interface between the supervisor core and its timer block
`timescale 1ns/1ps
`default_nettype none
interface lfs_tmr_if;
	logic sw_tick;
	logic mask_start;
	logic hic_start;
	logic reg_start;
	logic dg_open_cond;
	logic dg_short_cond;
	logic mask_busy;
	logic hic_busy;
	logic reg_done;
	logic dg_open_done;
	logic dg_short_done;
	// timer block side
	modport tmr (
		input sw_tick, mask_start, hic_start, reg_start, dg_open_cond, dg_short_cond,
		output mask_busy, hic_busy, reg_done, dg_open_done, dg_short_done
	);
	// supervisor side
	modport ctl (
		output sw_tick, mask_start, hic_start, reg_start, dg_open_cond, dg_short_cond,
		input mask_busy, hic_busy, reg_done, dg_open_done, dg_short_done
	);
endinterface
`default_nettype wire

// *** design/lfs_timers.sv ***
// mask, hiccup, regulation and deglitch timers of the led fault supervisor
`timescale 1ns/1ps
`default_nettype none
module lfs_timers import lfs_pkg::*; #(
	parameter int HIC_CYC = HICCUP_CYC,
	parameter int MSK_CYC = MASK_CYC,
	parameter int DG_CYC = DEGLITCH_CYC
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// timer requests and results
	lfs_tmr_if.tmr tif
);
	typedef struct packed {
		logic [CNT_W-1:0] mask_cnt;
		logic [CNT_W-1:0] hic_cnt;
		logic [REG_CNT_W-1:0] reg_cnt;
		logic [1:0][CNT_W-1:0] dg_cnt;
	} lfs_tmr_st_t;

	localparam logic [CNT_W-1:0] HIC_LD = CNT_W'(HIC_CYC);
	localparam logic [CNT_W-1:0] MSK_LD = CNT_W'(MSK_CYC); // R12
	localparam logic [CNT_W-1:0] DG_END = CNT_W'(DG_CYC); // R12
	localparam logic [REG_CNT_W-1:0] REG_END = REG_CNT_W'(REG_SW_CYCLES);

	lfs_tmr_st_t st_r;
	lfs_tmr_st_t st_nxt;
	logic [1:0] dg_cond;

	// saturating step toward a limit
	function automatic logic [CNT_W-1:0] lfs_sat_inc(input logic [CNT_W-1:0] v,
			input logic [CNT_W-1:0] lim);
		lfs_sat_inc = (v >= lim) ? lim : v + CNT_W'(1);
	endfunction

	assign dg_cond = {tif.dg_short_cond, tif.dg_open_cond};

	////////////////////////////////////////////////////////////////////////////
	// next state: fixed-length timers, lengths set only at build time
	always_comb begin
		st_nxt = st_r;
		// mask timer restarts on each pwm rising edge
		if (tif.mask_start) begin
			st_nxt.mask_cnt = MSK_LD; // R10 R16
		end else if (st_r.mask_cnt != '0) begin
			st_nxt.mask_cnt = st_r.mask_cnt - CNT_W'(1);
		end
		// hiccup off period between restart attempts
		if (tif.hic_start) begin
			st_nxt.hic_cnt = HIC_LD; // R15
		end else if (st_r.hic_cnt != '0) begin
			st_nxt.hic_cnt = st_r.hic_cnt - CNT_W'(1);
		end
		// regulation timer counts switching cycles, not pclk cycles
		if (tif.reg_start) begin
			st_nxt.reg_cnt = '0;
		end else if (tif.sw_tick && st_r.reg_cnt != REG_END) begin
			st_nxt.reg_cnt = st_r.reg_cnt + REG_CNT_W'(1); // R13
		end
		// deglitch: any gap in the condition starts the count over
		for (int i = 0; i < 2; i++) begin
			st_nxt.dg_cnt[i] = dg_cond[i] ? lfs_sat_inc(st_r.dg_cnt[i], DG_END) : '0; // R9 R16
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tif.mask_busy = (st_r.mask_cnt != '0);
	assign tif.hic_busy = (st_r.hic_cnt != '0);
	assign tif.reg_done = (st_r.reg_cnt == REG_END);
	assign tif.dg_open_done = (st_r.dg_cnt[0] == DG_END) && tif.dg_open_cond;
	assign tif.dg_short_done = (st_r.dg_cnt[1] == DG_END) && tif.dg_short_cond;

	// mask stays up for at least eight cycles once started
	a_mask_min_len: assert property (@(posedge pclk) disable iff (!presetn) // R10
		$rose(tif.mask_busy) |-> tif.mask_busy [*8])
		else $error("mask timer ended too early");

endmodule
`default_nettype wire

// *** design/lfs_supervisor.sv ***
// led driver fault supervisor: open and short detection, hiccup control, apb regs
// Functional notes
// R1: open detection masked when vin monitor below reference or dim level below 264 mV.
// R2: an asserted flag stays asserted under masking while the open fault persists.
// R3: open fault means sense voltage below 25% target at maximum duty, unmasked.
// R4: grounded threshold input always masks open faults; tied high never masks.
// R5: open fault enters hiccup and asserts flag through all hiccup periods.
// R6: flag releases after fault clears, after hiccup period, only while pwm high.
// R7: output short below 1.5 V with dim above 264 mV flags, no hiccup.
// R8: regulation resumes by itself once the short is removed.
// R9: open or short flags only after continuous activity for the deglitch time.
// R10: mask timer starts on pwm rise; faults ignored until it expires.
// R11: flag is latched at pwm fall and held while pwm is low.
// R12: deglitch and mask durations are fixed, not programmable.
// R13: 256 switching cycles pass before regulation-based faults are evaluated.
// R14: off-time is stretched when minimum on-time is too long for the output.
// R15: hiccup retries about every 1 ms.
// R16: deglitch and mask intervals are counters with build-time lengths.
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module lfs_supervisor import lfs_pkg::*; #(
	parameter int HIC_CYC = HICCUP_CYC,
	parameter int MSK_CYC = MASK_CYC,
	parameter int DG_CYC = DEGLITCH_CYC
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// host dimming input
	input wire logic pwm_in,
	// comparator results, high when the named condition is true
	input wire logic vin_mask_threshold_input,
	input wire logic analog_dim_input_ok,
	input wire logic sense_regulation_voltage_low,
	input wire logic max_duty,
	input wire logic vout_short_low,
	input wire logic min_on_limit,
	// one pulse per switching cycle
	input wire logic sw_cycle_tick,
	// fault flag and power stage controls
	output logic fault_flag_n,
	output logic switch_enable,
	output logic hiccup_active,
	output logic off_time_extend
);
	typedef struct packed {
		lfs_state_t state;
		logic pwm_d;
		logic sup_en;
		logic open_lat;
		logic short_flag;
		logic flag_n;
		logic sw_en;
		logic ext;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} lfs_top_st_t;

	lfs_top_st_t st_r;
	lfs_top_st_t st_nxt;
	lfs_tmr_if tif ();

	logic pwm_rise;
	logic open_raw;
	logic det_ok;
	logic open_cond;
	logic short_cond;
	logic open_set;
	logic open_clr;
	logic go_hic;
	logic go_rst;
	logic access;
	lfs_reg_t sel;
	logic [31:0] status;

	// map an address to a register
	function automatic lfs_reg_t lfs_decode(input logic [ADDR_W-1:0] a);
		if (a == OFF_CTRL) begin
			lfs_decode = LFS_REG_CTRL;
		end else if (a == OFF_STATUS) begin
			lfs_decode = LFS_REG_STATUS;
		end else begin
			lfs_decode = LFS_REG_NONE;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// timers
	lfs_timers #(
		.HIC_CYC(HIC_CYC),
		.MSK_CYC(MSK_CYC),
		.DG_CYC(DG_CYC)
	) u_timers (
		.pclk(pclk),
		.presetn(presetn),
		.tif(tif.tmr)
	);

	////////////////////////////////////////////////////////////////////////////
	// detection qualifiers
	assign pwm_rise = pwm_in && !st_r.pwm_d;
	assign open_raw = sense_regulation_voltage_low && max_duty; // R3
	// open detection needs unmasked timers, settled regulation and pwm on;
	// the rise edge itself is masked too, as the timer shows busy a cycle later
	assign det_ok = st_r.sup_en && !tif.mask_busy && tif.reg_done && pwm_in
		&& !pwm_rise && (st_r.state == LFS_RUN); // R10 R13
	// a strapped-low threshold input keeps this false forever, strapped high never
	assign open_cond = det_ok && vin_mask_threshold_input && analog_dim_input_ok
		&& open_raw; // R1 R3 R4
	// short depends on output voltage and dim level, not on regulation, so no regulation wait applies
	assign short_cond = st_r.sup_en && !tif.mask_busy && pwm_in && !pwm_rise
		&& analog_dim_input_ok && vout_short_low; // R7 R10
	assign open_set = (st_r.state == LFS_RUN) && tif.dg_open_done; // R9
	// release needs healthy regulation; under masking a live fault keeps it
	assign open_clr = st_r.open_lat && det_ok && !open_raw; // R2 R6
	assign go_hic = open_set;
	assign go_rst = (st_r.state == LFS_HIC) && !tif.hic_busy;

	// timer requests
	assign tif.sw_tick = sw_cycle_tick;
	assign tif.mask_start = pwm_rise; // R10
	assign tif.hic_start = go_hic; // R5 R15
	assign tif.reg_start = pwm_rise || go_rst; // R13
	assign tif.dg_open_cond = open_cond; // R9
	assign tif.dg_short_cond = short_cond; // R9

	// apb decode
	assign access = psel && penable;
	assign sel = lfs_decode(paddr);

	// status word seen by software
	always_comb begin
		status = '0;
		status[ST_FLAG_BIT] = st_r.flag_n;
		status[ST_OPEN_BIT] = st_r.open_lat;
		status[ST_SHORT_BIT] = st_r.short_flag;
		status[ST_HIC_BIT] = (st_r.state == LFS_HIC);
		status[ST_MASK_BIT] = tif.mask_busy;
		status[ST_REGOK_BIT] = tif.reg_done;
		status[ST_PWM_BIT] = st_r.pwm_d;
	end

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.pwm_d = pwm_in;
		// open fault latch: set wins, held across hiccup periods
		if (open_set) begin
			st_nxt.open_lat = 1'b1; // R5
		end else if (open_clr) begin
			st_nxt.open_lat = 1'b0; // R6
		end
		// short flag: set after deglitch, drops as soon as the short is gone
		if (tif.dg_short_done) begin
			st_nxt.short_flag = 1'b1; // R7 R9
		end else if (!vout_short_low) begin
			st_nxt.short_flag = 1'b0; // R8
		end
		// flag follows faults only while pwm is high, otherwise frozen
		if (pwm_in) begin
			st_nxt.flag_n = !(st_nxt.open_lat || st_nxt.short_flag); // R6 R7
		end else begin
			st_nxt.flag_n = st_r.flag_n; // R11
		end
		// hiccup sequencing; a short never gets here
		unique case (st_r.state)
			LFS_RUN: begin
				if (go_hic) begin
					st_nxt.state = LFS_HIC; // R5
				end
			end
			LFS_HIC: begin
				if (go_rst) begin
					st_nxt.state = LFS_RST; // R15
				end
			end
			LFS_RST: begin
				if (tif.reg_done) begin
					st_nxt.state = LFS_RUN; // R13
				end
			end
		endcase
		// switching stops for hiccup or while pwm is low; a short keeps switching
		st_nxt.sw_en = pwm_in && (st_nxt.state != LFS_HIC); // R7 R8
		// analog loop asks for longer off-time; pass it on while switching
		st_nxt.ext = min_on_limit && st_nxt.sw_en; // R14
		// apb: one wait state, answer registered so outputs stay glitch free
		st_nxt.pready = access && !st_r.pready;
		st_nxt.pslverr = 1'b0;
		st_nxt.prdata = '0;
		if (access && !st_r.pready) begin
			st_nxt.pslverr = (sel == LFS_REG_NONE);
			if (!pwrite && sel == LFS_REG_CTRL) begin
				st_nxt.prdata[CTRL_SUP_EN_BIT] = st_r.sup_en;
			end else if (!pwrite && sel == LFS_REG_STATUS) begin
				st_nxt.prdata = status;
			end
		end
		// write lands at the completing edge only
		if (access && st_r.pready && pwrite && sel == LFS_REG_CTRL && pstrb[0]) begin
			st_nxt.sup_en = pwdata[CTRL_SUP_EN_BIT];
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r.state <= LFS_RUN;
			st_r.pwm_d <= 1'b0;
			st_r.sup_en <= CTRL_SUP_EN_RST;
			st_r.open_lat <= 1'b0;
			st_r.short_flag <= 1'b0;
			st_r.flag_n <= 1'b1;
			st_r.sw_en <= 1'b0;
			st_r.ext <= 1'b0;
			st_r.pready <= 1'b0;
			st_r.pslverr <= 1'b0;
			st_r.prdata <= 32'h0000_0000;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata = st_r.prdata;
	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign fault_flag_n = st_r.flag_n;
	assign switch_enable = st_r.sw_en;
	assign hiccup_active = st_r.state[1]; // one-hot hiccup bit, no decode gate on the pin
	assign off_time_extend = st_r.ext;

	////////////////////////////////////////////////////////////////////////////
	// checks
	a_flag_hold_low: assert property (@(posedge pclk) disable iff (!presetn) // R11
		!pwm_in |=> $stable(fault_flag_n))
		else $error("fault flag moved while pwm low");

	a_open_vin_mask: assert property (@(posedge pclk) disable iff (!presetn) // R1
		tif.dg_open_cond |-> vin_mask_threshold_input && analog_dim_input_ok)
		else $error("open detection ran while masked");

	a_open_after_mask: assert property (@(posedge pclk) disable iff (!presetn) // R10
		(tif.dg_open_cond || tif.dg_short_cond) |-> !tif.mask_busy && !pwm_rise)
		else $error("detection ran inside mask time");

	a_open_reg_wait: assert property (@(posedge pclk) disable iff (!presetn) // R13
		tif.dg_open_cond |-> tif.reg_done && open_raw)
		else $error("open detection before regulation timer");

	a_open_hiccup: assert property (@(posedge pclk) disable iff (!presetn) // R5
		open_set |=> hiccup_active && !switch_enable && st_r.open_lat
		##1 !fault_flag_n || !pwm_in)
		else $error("open fault did not start hiccup");

	a_flag_in_hiccup: assert property (@(posedge pclk) disable iff (!presetn) // R5
		hiccup_active |-> st_r.open_lat)
		else $error("open latch dropped during hiccup");

	a_release_pwm: assert property (@(posedge pclk) disable iff (!presetn) // R6
		$rose(fault_flag_n) |-> $past(pwm_in) && !hiccup_active)
		else $error("flag released with pwm low or in hiccup");

	a_short_no_hic: assert property (@(posedge pclk) disable iff (!presetn) // R7
		(st_r.state == LFS_RUN && !tif.dg_open_done) |=> !hiccup_active)
		else $error("hiccup entered without open fault");

	a_short_clear: assert property (@(posedge pclk) disable iff (!presetn) // R8
		(st_r.short_flag && !vout_short_low && !tif.dg_short_done) |=> !st_r.short_flag)
		else $error("short flag stuck after short removed");

	a_short_deglitch: assert property (@(posedge pclk) disable iff (!presetn) // R9
		$rose(st_r.short_flag) |-> $past(tif.dg_short_cond, 1) && $past(tif.dg_short_done))
		else $error("short flagged without deglitch");

	a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
		(access && !pready) |=> pready ##1 !pready)
		else $error("apb answer not one wait state");

	a_offtime_ext: assert property (@(posedge pclk) disable iff (!presetn) // R14
		off_time_extend == ($past(min_on_limit) && switch_enable))
		else $error("off-time stretch does not follow min on-time limit");

endmodule
`default_nettype wire

// *** bench/lfs_host_model.sv ***
// host side model: drives the dimming pwm and samples the fault flag
`timescale 1ns/1ps
`default_nettype none
module lfs_host_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// command from the bench and flag from the device
	input wire logic pwm_cmd,
	input wire logic fault_flag_n,
	// pwm pin and the flag seen at the last pwm fall
	output logic pwm_out,
	output logic flag_at_fall
);
	////////////////////////////////////////////////////////////////////////////////
	// pwm idles high in reset, as the pin is pulled up; it moves only after an edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_out <= 1'b1;
			flag_at_fall <= 1'b1;
		end else begin
			pwm_out <= pwm_cmd;
			if (pwm_out && !pwm_cmd) begin
				flag_at_fall <= fault_flag_n;
			end
		end
	end
endmodule
`default_nettype wire

// *** bench/lfs_supervisor_bench.sv ***
// self-checking bench of the led fault supervisor
`timescale 1ns/1ps
`default_nettype none
module lfs_supervisor_bench import lfs_pkg::*;;
	// short counts keep the run brief
	localparam int HIC = 40;
	localparam int MSK = 20;
	localparam int DG = 10;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic pwm_cmd, pwm_in, flag_at_fall, sw_cycle_tick, max_duty, min_on_limit;
	logic vin_mask_threshold_input, analog_dim_input_ok, sense_regulation_voltage_low;
	logic vout_short_low, fault_flag_n, switch_enable, hiccup_active, off_time_extend;
	logic [1:0] tcnt;
	int fail_count, check_count;
	////////////////////////////////////////////////////////////////////////////////
	// device and host
	lfs_supervisor #(.HIC_CYC(HIC), .MSK_CYC(MSK), .DG_CYC(DG)) i_lfs_supervisor (
		.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .pwm_in, .vin_mask_threshold_input,
		.analog_dim_input_ok, .sense_regulation_voltage_low, .max_duty,
		.vout_short_low, .min_on_limit, .sw_cycle_tick, .fault_flag_n,
		.switch_enable, .hiccup_active, .off_time_extend
	);
	lfs_host_model i_lfs_host_model (
		.pclk, .presetn, .pwm_cmd, .fault_flag_n, .pwm_out(pwm_in), .flag_at_fall
	);
	////////////////////////////////////////////////////////////////////////////////
	// clock, and a switching tick every fourth cycle
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tcnt <= 2'h0;
			sw_cycle_tick <= 1'b0;
		end else begin
			tcnt <= tcnt + 2'h1;
			sw_cycle_tick <= (tcnt == 2'h3);
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge pclk);
	endtask
	// bounded wait for the flag, then judge it
	task automatic wait_flag(input logic exp, input int lim);
		int n;
		n = 0;
		while (fault_flag_n !== exp && n < lim) begin
			@(negedge pclk);
			n++;
		end
		chk(fault_flag_n, exp);
	endtask
	// one apb transfer; the answer is taken at the rising edge that sees pready high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) fail_count++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic give_verdict;
		if (fail_count == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_regs;
		apb(1'b0, OFF_CTRL, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, 8'h08, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		apb(1'b1, OFF_STATUS, 32'h7F);
		chk(err, 1'b0);
		apb(1'b1, OFF_CTRL, 32'h0);
		apb(1'b0, OFF_CTRL, 32'h0);
		chk(rd, 32'h0);
		// supervision off: a long short raises nothing
		@(posedge pclk);
		vout_short_low <= 1'b1;
		cyc(3 * DG);
		chk(fault_flag_n, 1'b1);
		@(posedge pclk);
		vout_short_low <= 1'b0;
		apb(1'b1, OFF_CTRL, 32'h1);
	endtask
	task automatic t_short;
		@(posedge pclk);
		vout_short_low <= 1'b1;
		repeat (DG - 2) @(posedge pclk);
		vout_short_low <= 1'b0;
		cyc(DG + 5);
		chk(fault_flag_n, 1'b1);
		@(posedge pclk);
		vout_short_low <= 1'b1;
		wait_flag(1'b0, DG + 6);
		chk({hiccup_active, switch_enable}, 2'h1);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(rd[ST_SHORT_BIT], 1'b1);
		// flag must stay frozen while pwm is low, even once the short is gone
		@(posedge pclk);
		pwm_cmd <= 1'b0;
		cyc(4);
		@(posedge pclk);
		vout_short_low <= 1'b0;
		cyc(20);
		chk({fault_flag_n, flag_at_fall}, 2'h0);
		@(posedge pclk);
		pwm_cmd <= 1'b1;
		wait_flag(1'b1, 8);
		@(posedge pclk);
		analog_dim_input_ok <= 1'b0;
		vout_short_low <= 1'b1;
		cyc(3 * DG);
		chk(fault_flag_n, 1'b1);
		@(posedge pclk);
		analog_dim_input_ok <= 1'b1;
		vout_short_low <= 1'b0;
	endtask
	task automatic t_mask;
		@(posedge pclk);
		pwm_cmd <= 1'b0;
		cyc(4);
		@(posedge pclk);
		vout_short_low <= 1'b1;
		pwm_cmd <= 1'b1;
		repeat (MSK - 2) @(posedge pclk);
		pwm_cmd <= 1'b0;
		cyc(3 * DG);
		chk(fault_flag_n, 1'b1);
		@(posedge pclk);
		pwm_cmd <= 1'b1;
		wait_flag(1'b0, MSK + DG + 8);
		@(posedge pclk);
		vout_short_low <= 1'b0;
		wait_flag(1'b1, 8);
	endtask
	task automatic t_offtime;
		@(posedge pclk);
		min_on_limit <= 1'b1;
		cyc(3);
		chk(off_time_extend, 1'b1);
		@(posedge pclk);
		pwm_cmd <= 1'b0;
		cyc(3);
		chk(off_time_extend, 1'b0);
		@(posedge pclk);
		min_on_limit <= 1'b0;
		pwm_cmd <= 1'b1;
	endtask
	task automatic t_open;
		@(posedge pclk);
		pwm_cmd <= 1'b0;
		cyc(4);
		@(posedge pclk);
		pwm_cmd <= 1'b1;
		cyc(900);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(rd[ST_REGOK_BIT], 1'b0);
		cyc(200);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(rd[ST_REGOK_BIT], 1'b1);
		// grounded threshold input, then low dim level, both hide the open
		@(posedge pclk);
		vin_mask_threshold_input <= 1'b0;
		sense_regulation_voltage_low <= 1'b1;
		max_duty <= 1'b1;
		cyc(3 * DG);
		chk(fault_flag_n, 1'b1);
		@(posedge pclk);
		vin_mask_threshold_input <= 1'b1;
		analog_dim_input_ok <= 1'b0;
		cyc(3 * DG);
		chk(fault_flag_n, 1'b1);
		@(posedge pclk);
		analog_dim_input_ok <= 1'b1;
		wait_flag(1'b0, DG + 8);
		chk({hiccup_active, switch_enable}, 2'h2);
		cyc(HIC - 4);
		chk(hiccup_active, 1'b1);
		@(posedge pclk);
		vin_mask_threshold_input <= 1'b0;
		cyc(3 * HIC);
		chk(fault_flag_n, 1'b0);
		chk({hiccup_active, switch_enable}, 2'h1);
		// clear with pwm low: no release until pwm is high again
		@(posedge pclk);
		pwm_cmd <= 1'b0;
		vin_mask_threshold_input <= 1'b1;
		sense_regulation_voltage_low <= 1'b0;
		max_duty <= 1'b0;
		cyc(1500);
		chk(fault_flag_n, 1'b0);
		@(posedge pclk);
		pwm_cmd <= 1'b1;
		wait_flag(1'b1, 1600);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// main sequence and watchdog
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{max_duty, min_on_limit, sense_regulation_voltage_low, vout_short_low} = '0;
		{vin_mask_threshold_input, analog_dim_input_ok, pwm_cmd} = 3'h7;
		pstrb = 4'hF;
		presetn = 1'b0;
		fail_count = 0;
		check_count = 0;
		repeat (4) @(posedge pclk);
		chk({fault_flag_n, pready, switch_enable, hiccup_active}, 4'h8);
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_short();
		t_mask();
		t_offtime();
		t_open();
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		give_verdict();
	end
endmodule
`default_nettype wire
